// file: common/mdp_defines.svh
`ifndef MDP_DEFINES_SVH
`define MDP_DEFINES_SVH
// alu function codes
`define MDP_ALU_AND 5'h00
`define MDP_ALU_ADD_A_CARRY 5'h01
`define MDP_ALU_ADD_B_CARRY 5'h02
`define MDP_ALU_ADD_A_B_CARRY 5'h03
`define MDP_ALU_AND_INV_A 5'h04
`define MDP_ALU_INV_A_PLUS_CARRY 5'h05
`define MDP_ALU_INV_B_PLUS_CARRY 5'h06
`define MDP_ALU_IOR 5'h07
`define MDP_ALU_NAND 5'h08
`define MDP_ALU_INCLUSIVE_NOR_OP 5'h09
`define MDP_ALU_SUB_A_FROM_B 5'h0a
`define MDP_ALU_SUB_B_FROM_A 5'h0b
`define MDP_ALU_SPECIAL 5'h0c
`define MDP_ALU_XNOR 5'h0d
`define MDP_ALU_XOR 5'h0e
`define MDP_ALU_ZERO 5'h0f
// b-bus source codes
`define MDP_B_COND_ACCUM 5'h00
`define MDP_B_COUNTER 5'h01
`define MDP_B_COND_INDEX 5'h02
`define MDP_B_GENERAL_IDX 5'h03
`define MDP_B_INT_STATUS 5'h04
`define MDP_B_INDEX 5'h05
`define MDP_B_PRIV_IDX 5'h06
`define MDP_B_Q 5'h07
`define MDP_B_MAP 5'h08
`define MDP_B_SWITCH 5'h09
`define MDP_B_SPECIAL_IDX 5'h0a
`define MDP_B_T 5'h0b
`define MDP_B_EXTERNAL 5'h0c
// store destination codes
`define MDP_S_NOP 5'h00
`define MDP_S_COND_ACCUM 5'h01
`define MDP_S_COUNTER 5'h02
`define MDP_S_COND_INDEX 5'h03
`define MDP_S_COND_WRITE 5'h04
`define MDP_S_GENERAL_IDX 5'h05
`define MDP_S_INT_STATUS 5'h06
`define MDP_S_LED 5'h07
`define MDP_S_INDEX 5'h08
`define MDP_S_MAP 5'h09
`define MDP_S_PRIV_IDX 5'h0a
`define MDP_S_SPECIAL_IDX 5'h0b
`define MDP_S_EXTERNAL 5'h0c
// condition codes
`define MDP_C_NONE 4'h0
`define MDP_C_OVERFLOW 4'h1
`define MDP_C_CARRY 4'h2
`define MDP_C_CNT_ZERO 4'h3
`define MDP_C_CNT_NIB_ZERO 4'h4
`define MDP_C_INT_PEND 4'h5
`define MDP_C_FETCH_SUPP 4'h6
`define MDP_C_SHIFT 4'h7
`define MDP_C_Y_SIGN 4'h8
`define MDP_C_Y_ZERO 4'h9
`define MDP_C_B_SIGN 4'ha
// field positions
`define MDP_SIGN_BIT 15
`define MDP_ACC_SEL_BIT 11
`define MDP_IDX_SEL_BIT 3
`define MDP_MAP_RD_PROT_BIT 15
`define MDP_MAP_WR_PROT_BIT 14
`define MDP_MAP_PAGE_RD_MSB 9
`define MDP_MAP_PAGE_WR_MSB 13
`define MDP_INDEX_MSB 3
// special word type that forces ones
`define MDP_WORD_TYPE_JUMP_MOD 3'h5
// reset values and the special-function ones value
`define MDP_RST_WORD 16'h0000
`define MDP_RST_LED 16'hffff
`define MDP_SPECIAL_ONES 16'hffff
`endif

// file: common/mdp_pkg.sv
package mdp_pkg;
  typedef logic [15:0] mdp_word_t;
  typedef enum logic [2:0] {
    MDP_IDLE = 3'b001,
    MDP_WAIT = 3'b010,
    MDP_FETCH_WAIT = 3'b100
  } mdp_rd_state_t;
  typedef struct packed {
    logic ovf;
    logic carry;
    logic shift_f;
    logic y_sign;
    logic y_zero;
    logic b_sign;
  } mdp_flags_t;
endpackage : mdp_pkg

// file: sim/mdp_datapath_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mdp_defines.svh"
module mdp_datapath_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] alu_func = `MDP_ALU_ZERO;
  logic [4:0] bbus_src = `MDP_B_COUNTER;
  logic [4:0] store_dst = `MDP_S_NOP;
  logic [3:0] condition_field = `MDP_C_NONE;
  logic [6:0] ctl = 7'h00;
  logic [15:0] a_bus = 16'h0000;
  logic [15:0] switch_pins = 16'h00a5;
  logic cond_true, stall, read_done, jump_modify, mem_write, mem_read, fetch_issue, ext_store;
  logic [15:0] y_bus, b_bus, mem_addr, mem_wdata, status_led_latch, read_data, ext_store_data;
  logic [3:0] jump_nibble;
  logic [16:0] r;
  int bad_count = 0;
  int checked = 0;
  int i;
  // clock
  always #25 clk = ~clk;
  // ctl: int_event, cin override, cin value, fetch, qualified req, shift, shift bit=a/b read
  mdp_datapath mdp_datapath_inst (.clk, .sys_rst, .word_type(`MDP_WORD_TYPE_JUMP_MOD),
    .alu_func, .bbus_src, .store_dst, .condition_field, .carry_in_ovr(ctl[5]),
    .carry_in_val(ctl[4]), .fetch_req(ctl[3]), .read_req(1'b0), .read_ab_addr(ctl[0]),
    .shift_en(ctl[1]), .shift_out_bit(ctl[0]), .a_bus, .q_reg(16'h1357),
    .ext_bbus(16'h0000), .int_event(ctl[6]), .int_req_qual(ctl[2]), .read_done,
    .read_data, .switch_pins, .cond_true, .stall, .y_bus, .b_bus, .b_bus_driven(),
    .mem_write, .mem_read, .mem_addr, .mem_wdata, .fetch_issue, .jump_modify,
    .jump_nibble, .status_led_latch, .ext_store_data, .ext_store);
  mdp_mem_model #(.DLY(3), .DATA(16'h9c35)) mdp_mem_model_inst (.clk, .fetch_issue,
    .mem_read, .read_done, .read_data);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic uop(input logic [4:0] f, input logic [4:0] bs, input logic [4:0] sd,
    input logic [3:0] cn, input logic [6:0] c, input logic [15:0] a);
    @(negedge clk);
    alu_func = f;
    bbus_src = bs;
    store_dst = sd;
    condition_field = cn;
    ctl = c;
    a_bus = a;
    #1;
  endtask : uop
  task automatic st(input logic [4:0] sd, input logic [15:0] v);
    uop(`MDP_ALU_ADD_A_CARRY, `MDP_B_COUNTER, sd, `MDP_C_NONE, 7'h00, v);
  endtask : st
  task automatic rd(input logic [4:0] bs, input logic [3:0] cn);
    uop(`MDP_ALU_ADD_B_CARRY, bs, `MDP_S_NOP, cn, 7'h00, 16'h0000);
  endtask : rd
  task automatic zc(input logic [3:0] cn, input logic [6:0] c);
    uop(`MDP_ALU_ZERO, `MDP_B_COUNTER, `MDP_S_NOP, cn, c, 16'h0000);
  endtask : zc
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_go();
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk("stall end", 16'h0000, 16'(n == 20));
  endtask : wait_go
  function automatic logic [16:0] ref_alu(input logic [4:0] f, input logic [15:0] a,
    input logic [15:0] b);
    logic c;
    c = (f == `MDP_ALU_SUB_A_FROM_B || f == `MDP_ALU_SUB_B_FROM_A);
    case (f)
      `MDP_ALU_AND: ref_alu = {1'b0, a & b};
      `MDP_ALU_ADD_A_CARRY: ref_alu = {1'b0, a} + 17'(c);
      `MDP_ALU_ADD_B_CARRY: ref_alu = {1'b0, b} + 17'(c);
      `MDP_ALU_ADD_A_B_CARRY: ref_alu = {1'b0, a} + {1'b0, b} + 17'(c);
      `MDP_ALU_AND_INV_A: ref_alu = {1'b0, b & ~a};
      `MDP_ALU_INV_A_PLUS_CARRY: ref_alu = {1'b0, ~a} + 17'(c);
      `MDP_ALU_INV_B_PLUS_CARRY: ref_alu = {1'b0, ~b} + 17'(c);
      `MDP_ALU_IOR: ref_alu = {1'b0, a | b};
      `MDP_ALU_NAND: ref_alu = {1'b0, ~(a & b)};
      `MDP_ALU_INCLUSIVE_NOR_OP: ref_alu = {1'b0, ~(a | b)};
      `MDP_ALU_SUB_A_FROM_B: ref_alu = {1'b0, b} + {1'b0, ~a} + 17'(c);
      `MDP_ALU_SUB_B_FROM_A: ref_alu = {1'b0, a} + {1'b0, ~b} + 17'(c);
      `MDP_ALU_XNOR: ref_alu = {1'b0, ~(a ^ b)};
      `MDP_ALU_XOR: ref_alu = {1'b0, a ^ b};
      default: ref_alu = 17'h00000;
    endcase
  endfunction : ref_alu
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // watchdog and tests
  // ----------------------------------------
  initial begin
    #(4000 * 50);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd(`MDP_B_COUNTER, `MDP_C_NONE);
    chk("counter", 16'h0000, y_bus);
    chk("leds", 16'hffff, status_led_latch);
    zc(`MDP_C_Y_ZERO, 7'h00);
    chk("y zero", 16'h0001, 16'(cond_true));
    $display("test reset done");
    st(`MDP_S_COUNTER, 16'h0001);
    for (i = 0; i < 15; i++) begin
      if (i == 12) continue;
      r = ref_alu(5'(i), 16'h7fff, 16'h0001);
      uop(5'(i), `MDP_B_COUNTER, `MDP_S_NOP, `MDP_C_NONE, 7'h00, 16'h7fff);
      chk("alu", r[15:0], y_bus);
      zc(`MDP_C_CARRY, 7'h00);
      chk("carry", 16'(r[16]), 16'(cond_true));
      chk("zero", 16'h0000, y_bus);
      zc(`MDP_C_OVERFLOW, 7'h00);
      chk("ovf", 16'(i == 3), 16'(cond_true));
    end
    uop(`MDP_ALU_ADD_A_CARRY, `MDP_B_COUNTER, `MDP_S_NOP, `MDP_C_NONE, 7'h30, 16'h7fff);
    chk("cin", 16'h8000, y_bus);
    $display("test alu done");
    st(`MDP_S_COUNTER, 16'h0011);
    rd(`MDP_B_COUNTER, `MDP_C_NONE);
    rd(`MDP_B_COUNTER, `MDP_C_CNT_NIB_ZERO);
    chk("nib", 16'h0000, 16'(cond_true));
    rd(`MDP_B_COUNTER, `MDP_C_CNT_NIB_ZERO);
    chk("nib", 16'h0001, 16'(cond_true));
    chk("count", 16'h0010, y_bus);
    rd(`MDP_B_COUNTER, `MDP_C_CNT_ZERO);
    chk("all", 16'h0000, 16'(cond_true));
    uop(`MDP_ALU_SPECIAL, `MDP_B_COUNTER, `MDP_S_NOP, `MDP_C_NONE, 7'h00, 16'h0000);
    chk("special_alu_select", 16'hffff, y_bus);
    chk("jmod", 16'h000e, 16'(jump_nibble));
    $display("test counter done");
    for (i = 0; i < 2; i++) begin
      st(`MDP_S_COUNTER, i ? 16'h0808 : 16'h0000);
      st(`MDP_S_COND_ACCUM, i ? 16'h2222 : 16'h1111);
      st(`MDP_S_COND_INDEX, i ? 16'h4444 : 16'h3333);
    end
    for (i = 0; i < 2; i++) begin
      st(`MDP_S_COUNTER, i ? 16'h0808 : 16'h0000);
      rd(`MDP_B_COND_ACCUM, `MDP_C_NONE);
      chk("accum", i ? 16'h2222 : 16'h1111, y_bus);
      rd(`MDP_B_COND_INDEX, `MDP_C_NONE);
      chk("index", i ? 16'h4444 : 16'h3333, y_bus);
    end
    st(`MDP_S_SPECIAL_IDX, 16'h0003);
    st(`MDP_S_MAP, 16'hfdff);
    rd(`MDP_B_MAP, `MDP_C_NONE);
    chk("map", 16'hc1ff, y_bus);
    st(`MDP_S_LED, 16'h5a0f);
    rd(`MDP_B_SWITCH, `MDP_C_NONE);
    chk("leds", 16'h5a0f, status_led_latch);
    chk("switch", 16'h00a5, y_bus);
    rd(`MDP_B_Q, `MDP_C_NONE);
    chk("q", 16'h1357, y_bus);
    st(`MDP_S_EXTERNAL, 16'h6b1d);
    chk("ext", 16'h6b1d, ext_store ? ext_store_data : 16'h0);
    $display("test selects done");
    for (i = 0; i < 2; i++) begin
      st(`MDP_S_COUNTER, i ? 16'h8123 : 16'h0123);
      st(`MDP_S_COND_WRITE, 16'h4d2e);
      chk("write", 16'(i == 0), 16'(mem_write));
      chk("read", 16'(i == 1), 16'(mem_read));
      chk("addr", i ? 16'h8123 : 16'h0123, mem_addr);
      chk("wdata", 16'h4d2e, mem_wdata);
    end
    uop(`MDP_ALU_ADD_B_CARRY, `MDP_B_T, `MDP_S_NOP, `MDP_C_NONE, 7'h01, 16'h0000);
    chk("ab", 16'h2222, y_bus);
    rd(`MDP_B_T, `MDP_C_NONE);
    chk("stall", 16'h0001, 16'(stall));
    wait_go();
    chk("t", 16'h9c35, y_bus);
    zc(`MDP_C_NONE, 7'h08);
    chk("fetch", 16'h0001, 16'(fetch_issue));
    rd(`MDP_B_T, `MDP_C_NONE);
    chk("stall", 16'h0001, 16'(stall));
    wait_go();
    chk("t", 16'h9c35, y_bus);
    rd(`MDP_B_COUNTER, `MDP_C_NONE);
    chk("ir", 16'h9c35, y_bus);
    zc(`MDP_C_Y_SIGN, 7'h00);
    chk("y sign", 16'h0001, 16'(cond_true));
    $display("test memory done");
    for (i = 0; i < 4; i++) begin
      zc(`MDP_C_INT_PEND, 7'h40);
      if (i > 1) chk("pend", 16'(i == 3), 16'(cond_true));
    end
    zc(`MDP_C_NONE, 7'h4c);
    chk("fetch", 16'h0000, 16'(fetch_issue));
    zc(`MDP_C_FETCH_SUPP, 7'h00);
    chk("supp", 16'h0001, 16'(cond_true));
    uop(`MDP_ALU_ZERO, `MDP_B_COUNTER, `MDP_S_INT_STATUS, `MDP_C_NONE, 7'h00, 16'h0000);
    zc(`MDP_C_FETCH_SUPP, 7'h00);
    chk("supp", 16'h0000, 16'(cond_true));
    uop(`MDP_ALU_ADD_A_CARRY, `MDP_B_COUNTER, `MDP_S_NOP, `MDP_C_NONE, 7'h03, 16'h0000);
    zc(`MDP_C_SHIFT, 7'h02);
    chk("shift", 16'h0001, 16'(cond_true));
    zc(`MDP_C_SHIFT, 7'h00);
    chk("shift", 16'h0001, 16'(cond_true));
    $display("test flags done");
    tally_and_finish();
  end
endmodule : mdp_datapath_bench
`default_nettype wire

// file: sim/mdp_datapath_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "mdp_defines.svh"
module mdp_datapath_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // microinstruction fields
  input wire logic [2:0] word_type,
  input wire logic [4:0] alu_func,
  input wire logic [4:0] bbus_src,
  input wire logic [4:0] store_dst,
  input wire logic [3:0] condition_field,
  input wire logic read_done,
  // outputs watched
  input wire logic cond_true,
  input wire logic stall,
  input wire logic [15:0] y_bus,
  input wire logic [15:0] b_bus,
  input wire logic b_bus_driven,
  input wire logic mem_write,
  input wire logic jump_modify,
  input wire logic [15:0] status_led_latch
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_zero_out: assert property (alu_func == `MDP_ALU_ZERO |-> y_bus == 16'h0000)
    else $error("zero function output not zero");
  a_logic_clr: assert property ((!stall && alu_func inside {`MDP_ALU_AND, `MDP_ALU_AND_INV_A,
    `MDP_ALU_IOR, `MDP_ALU_NAND, `MDP_ALU_INCLUSIVE_NOR_OP, `MDP_ALU_XNOR, `MDP_ALU_XOR})
    ##1 (condition_field == `MDP_C_CARRY) |-> !cond_true)
    else $error("carry left set by logical function");
  a_ysign_track: assert property ((!stall && alu_func != `MDP_ALU_ZERO)
    ##1 (condition_field == `MDP_C_Y_SIGN) |-> cond_true == $past(y_bus[15]))
    else $error("y sign condition wrong");
  a_yzero_track: assert property ((!stall && alu_func != `MDP_ALU_ZERO)
    ##1 (condition_field == `MDP_C_Y_ZERO) |-> cond_true == ($past(y_bus) == 16'h0000))
    else $error("y zero condition wrong");
  a_cnt_dec: assert property ((!stall && !read_done && bbus_src == `MDP_B_COUNTER
    && store_dst != `MDP_S_COUNTER && condition_field inside {`MDP_C_CNT_ZERO,
    `MDP_C_CNT_NIB_ZERO}) ##1 (bbus_src == `MDP_B_COUNTER) |-> b_bus == $past(b_bus) - 16'h0001)
    else $error("counter not decremented by zero test");
  a_cwrite_sel: assert property ((!stall && store_dst == `MDP_S_COND_WRITE)
    |-> mem_write == !b_bus[15])
    else $error("conditional write picked wrongly");
  a_q_hidden: assert property (bbus_src == `MDP_B_Q |-> !b_bus_driven)
    else $error("q driven on b-bus");
  a_special_alu_select_ones: assert property ((alu_func == `MDP_ALU_SPECIAL && word_type == 3'h5)
    |-> y_bus == 16'hffff && jump_modify)
    else $error("special in type five not all ones");
  a_led_latch: assert property ((!stall && store_dst == `MDP_S_LED)
    |=> status_led_latch == $past(y_bus))
    else $error("led latch missed store");
  a_led_keep: assert property ((stall || store_dst != `MDP_S_LED)
    |=> $stable(status_led_latch))
    else $error("led latch changed without store");
endmodule : mdp_datapath_chk
bind mdp_datapath mdp_datapath_chk mdp_datapath_chk_inst (.clk, .sys_rst, .word_type,
  .alu_func, .bbus_src, .store_dst, .condition_field, .read_done, .cond_true, .stall,
  .y_bus, .b_bus, .b_bus_driven, .mem_write, .jump_modify, .status_led_latch);
`default_nettype wire

// file: sim/mdp_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mdp_mem_model #(
  parameter int DLY = 3,
  parameter logic [15:0] DATA = 16'h9c35
) (
  // clock
  input wire logic clk,
  // requests
  input wire logic fetch_issue,
  input wire logic mem_read,
  // answer
  output logic read_done,
  output logic [15:0] read_data
);
  int cnt = 0;
  initial read_done = 1'b0;
  initial read_data = ~DATA;
  // take one read at a time, count its latency
  always @(posedge clk) begin
    if (cnt == 0 && (fetch_issue || mem_read)) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // answer one cycle, data toggles outside the answer
  always @(negedge clk) begin
    read_done <= (cnt == 1);
    read_data <= (cnt == 1) ? DATA : ~read_data;
  end
endmodule : mdp_mem_model
`default_nettype wire

// file: verilog/mdp_alu.sv
`timescale 1ns/1ns
`default_nettype none
`include "mdp_defines.svh"
module mdp_alu #(
  parameter int WIDTH = 16
) (
  // operands
  input wire logic [4:0] alu_func,
  input wire logic [WIDTH-1:0] a_op,
  input wire logic [WIDTH-1:0] b_op,
  input wire logic carry_in_ovr,
  input wire logic carry_in_val,
  // results
  output logic [WIDTH-1:0] f_out,
  output logic carry_out,
  output logic ovf_out
);
  initial begin
    if (WIDTH < 16) $error("mdp_alu needs at least 16 bits");
  end
  logic [WIDTH:0] sum;
  logic [WIDTH-1:0] x;
  logic [WIDTH-1:0] y;
  logic cin;
  // operand routing and arithmetic
  always_comb begin
    x = '0;
    y = '0;
    cin = carry_in_ovr ? carry_in_val : 1'b0;
    f_out = '0;
    carry_out = 1'b0;
    ovf_out = 1'b0;
    sum = '0;
    case (alu_func)
      `MDP_ALU_ADD_A_CARRY: x = a_op;
      `MDP_ALU_ADD_B_CARRY: x = b_op;
      `MDP_ALU_ADD_A_B_CARRY: begin
        x = a_op;
        y = b_op;
      end
      `MDP_ALU_INV_A_PLUS_CARRY: x = ~a_op;
      `MDP_ALU_INV_B_PLUS_CARRY: x = ~b_op;
      `MDP_ALU_SUB_A_FROM_B: begin
        x = b_op;
        y = ~a_op;
        cin = carry_in_ovr ? carry_in_val : 1'b1;
      end
      `MDP_ALU_SUB_B_FROM_A: begin
        x = a_op;
        y = ~b_op;
        cin = carry_in_ovr ? carry_in_val : 1'b1;
      end
      default: ;
    endcase
    sum = {1'b0, x} + {1'b0, y} + {{WIDTH{1'b0}}, cin};
    f_out = sum[WIDTH-1:0];
    carry_out = sum[WIDTH];
    ovf_out = (x[WIDTH-1] == y[WIDTH-1]) && (sum[WIDTH-1] != x[WIDTH-1]);
    // logical functions clear carry and overflow
    case (alu_func)
      `MDP_ALU_AND: f_out = a_op & b_op;
      `MDP_ALU_AND_INV_A: f_out = b_op & ~a_op;
      `MDP_ALU_IOR: f_out = a_op | b_op;
      `MDP_ALU_NAND: f_out = ~(a_op & b_op);
      `MDP_ALU_INCLUSIVE_NOR_OP: f_out = ~(a_op | b_op);
      `MDP_ALU_XOR: f_out = a_op ^ b_op;
      `MDP_ALU_XNOR: f_out = ~(a_op ^ b_op);
      `MDP_ALU_ZERO, `MDP_ALU_SPECIAL: f_out = '0;
      default: ;
    endcase
    case (alu_func)
      `MDP_ALU_AND, `MDP_ALU_AND_INV_A, `MDP_ALU_IOR, `MDP_ALU_NAND, `MDP_ALU_INCLUSIVE_NOR_OP,
      `MDP_ALU_XOR, `MDP_ALU_XNOR, `MDP_ALU_ZERO, `MDP_ALU_SPECIAL: begin
        carry_out = 1'b0;
        ovf_out = 1'b0;
      end
      default: ;
    endcase
  end
endmodule : mdp_alu
`default_nettype wire

// file: verilog/mdp_datapath.sv
// What this block does
// - overflow flag latched, held under zero function
// - carry flag latched, held under zero function
// - counter zero tests decrement, invalid after load
// - interrupt pending lags event three cycles
// - fetch suppression sets flop, status store clears
// - shift flag captures shifted-out bit
// - y sign and zero flags from y-bus
// - logical functions clear carry and overflow
// - additive functions default carry-in zero
// - subtract functions default carry-in one
// - special function forces ones in type five
// - zero function outputs zero, holds flags
// - counter bit 11 picks accumulator a/b
// - counter bit 3 picks index x/y
// - fetched word loads t and counter
// - index bits 0-3 select indexed entries
// - q feeds alu internally, not b-bus
// - map read gives protects and page
// - map store writes protects and page
// - t before read returns stalls processor
// - conditional write by b-bus sign bit
// - leds latch y-bus, switches read through two sync flops
`timescale 1ns/1ns
`default_nettype none
`include "mdp_defines.svh"
module mdp_datapath #(
  parameter int WIDTH = 16,
  parameter int FILE_DEPTH = 16,
  parameter int MAP_DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // microinstruction fields
  input wire logic [2:0] word_type,
  input wire logic [4:0] alu_func,
  input wire logic [4:0] bbus_src,
  input wire logic [4:0] store_dst,
  input wire logic [3:0] condition_field,
  input wire logic carry_in_ovr,
  input wire logic carry_in_val,
  input wire logic fetch_req,
  input wire logic read_req,
  input wire logic read_ab_addr,
  input wire logic shift_en,
  input wire logic shift_out_bit,
  input wire logic [WIDTH-1:0] a_bus,
  input wire logic [WIDTH-1:0] q_reg,
  input wire logic [WIDTH-1:0] ext_bbus,
  // backplane side
  input wire logic int_event,
  input wire logic int_req_qual,
  input wire logic read_done,
  input wire logic [WIDTH-1:0] read_data,
  input wire logic [WIDTH-1:0] switch_pins,
  // outputs
  output logic cond_true,
  output logic stall,
  output logic [WIDTH-1:0] y_bus,
  output logic [WIDTH-1:0] b_bus,
  output logic b_bus_driven,
  output logic mem_write,
  output logic mem_read,
  output logic [WIDTH-1:0] mem_addr,
  output logic [WIDTH-1:0] mem_wdata,
  output logic fetch_issue,
  output logic jump_modify,
  output logic [3:0] jump_nibble,
  output logic [WIDTH-1:0] status_led_latch,
  output logic [WIDTH-1:0] ext_store_data,
  output logic ext_store
);
  initial begin
    if (WIDTH != 16) $error("mdp_datapath supports 16-bit words only");
    if (FILE_DEPTH != 16) $error("index field selects exactly 16 entries");
    if (MAP_DEPTH < 2) $error("map depth too small");
  end
  localparam int MW = $clog2(MAP_DEPTH);
  typedef struct packed {
    mdp_pkg::mdp_flags_t flags;
    logic [WIDTH-1:0] acc_a;
    logic [WIDTH-1:0] acc_b;
    logic [WIDTH-1:0] idx_x;
    logic [WIDTH-1:0] idx_y;
    logic [WIDTH-1:0] counter_instr_reg;
    logic [WIDTH-1:0] t_reg;
    logic [WIDTH-1:0] index_reg;
    logic [WIDTH-1:0] interrupt_status_reg;
    logic [WIDTH-1:0] map_pointer_reg;
    logic [WIDTH-1:0] status_led_latch;
    logic [WIDTH-1:0] switch_meta;
    logic [WIDTH-1:0] switch_input_reg;
    logic int_meta;
    logic int_sync;
    logic interrupt_pending_cond;
    logic fetch_suppressed_flop;
    mdp_pkg::mdp_rd_state_t rd_state;
  } mdp_state_t;
  mdp_state_t st;
  mdp_state_t next_st;
  logic [WIDTH-1:0] gen_file [FILE_DEPTH];
  logic [WIDTH-1:0] priv_file [FILE_DEPTH];
  logic [WIDTH-1:0] map_file [MAP_DEPTH];
  logic [WIDTH-1:0] f_out;
  logic alu_carry;
  logic alu_ovf;
  logic [WIDTH-1:0] b_src;
  logic [WIDTH-1:0] b_alu;
  logic [3:0] idx;
  logic [MW-1:0] map_idx;
  logic t_wait;
  logic zero_fn;
  logic do_store;
  // indexed entry from the low index bits
  function automatic logic [3:0] mdp_index(input logic [WIDTH-1:0] r);
    mdp_index = r[`MDP_INDEX_MSB:0];
  endfunction : mdp_index
  assign idx = mdp_index(st.index_reg);
  assign map_idx = st.map_pointer_reg[MW-1:0];
  assign zero_fn = (alu_func == `MDP_ALU_ZERO);
  assign t_wait = (st.rd_state != mdp_pkg::MDP_IDLE);
  // ----------------------------------------
  // b-bus source selection
  // ----------------------------------------
  always_comb begin
    b_src = '0;
    case (bbus_src)
      `MDP_B_COND_ACCUM: b_src = st.counter_instr_reg[`MDP_ACC_SEL_BIT] ? st.acc_b : st.acc_a;
      `MDP_B_COUNTER: b_src = st.counter_instr_reg;
      `MDP_B_COND_INDEX: b_src = st.counter_instr_reg[`MDP_IDX_SEL_BIT] ? st.idx_y : st.idx_x;
      `MDP_B_GENERAL_IDX: b_src = gen_file[idx];
      `MDP_B_PRIV_IDX: b_src = priv_file[idx];
      `MDP_B_SPECIAL_IDX: b_src = (idx == 4'h0) ? st.map_pointer_reg : ext_bbus;
      `MDP_B_INT_STATUS: b_src = st.interrupt_status_reg;
      `MDP_B_INDEX: b_src = st.index_reg;
      `MDP_B_MAP: begin
        b_src = '0;
        b_src[`MDP_MAP_RD_PROT_BIT] = map_file[map_idx][`MDP_MAP_RD_PROT_BIT];
        b_src[`MDP_MAP_WR_PROT_BIT] = map_file[map_idx][`MDP_MAP_WR_PROT_BIT];
        b_src[`MDP_MAP_PAGE_RD_MSB:0] = map_file[map_idx][`MDP_MAP_PAGE_RD_MSB:0];
      end
      `MDP_B_SWITCH: b_src = st.switch_input_reg;
      `MDP_B_T: begin
        if (t_wait && read_ab_addr) begin
          b_src = st.counter_instr_reg[0] ? st.acc_b : st.acc_a;
        end else begin
          b_src = st.t_reg;
        end
      end
      `MDP_B_EXTERNAL: b_src = ext_bbus;
      default: b_src = '0;
    endcase
  end
  // q goes straight to the alu and never onto the bus
  assign b_alu = (bbus_src == `MDP_B_Q) ? q_reg : b_src;
  assign b_bus = b_src;
  assign b_bus_driven = (bbus_src != `MDP_B_Q);
  assign stall = (bbus_src == `MDP_B_T) && t_wait && !read_ab_addr;
  assign do_store = !stall;
  mdp_alu #(
    .WIDTH(WIDTH)
  ) u_alu (
    .alu_func(alu_func),
    .a_op(a_bus),
    .b_op(b_alu),
    .carry_in_ovr(carry_in_ovr),
    .carry_in_val(carry_in_val),
    .f_out(f_out),
    .carry_out(alu_carry),
    .ovf_out(alu_ovf)
  );
  // special function in the jump-modify word type drives ones
  always_comb begin
    y_bus = f_out;
    jump_modify = 1'b0;
    if (alu_func == `MDP_ALU_SPECIAL && word_type == `MDP_WORD_TYPE_JUMP_MOD) begin
      y_bus = `MDP_SPECIAL_ONES;
      jump_modify = 1'b1;
    end
  end
  assign jump_nibble = st.counter_instr_reg[3:0];
  // ----------------------------------------
  // memory and external strobes
  // ----------------------------------------
  assign mem_addr = b_src;
  assign mem_wdata = y_bus;
  assign mem_write = do_store && store_dst == `MDP_S_COND_WRITE && !b_src[`MDP_SIGN_BIT];
  assign mem_read = do_store && ((store_dst == `MDP_S_COND_WRITE && b_src[`MDP_SIGN_BIT])
      || read_req);
  assign fetch_issue = do_store && fetch_req && !(int_req_qual && st.interrupt_pending_cond);
  assign ext_store = do_store && (store_dst == `MDP_S_EXTERNAL
      || (store_dst == `MDP_S_SPECIAL_IDX && idx != 4'h0));
  assign ext_store_data = y_bus;
  assign status_led_latch = st.status_led_latch;
  // condition multiplexer
  always_comb begin
    case (condition_field)
      `MDP_C_OVERFLOW: cond_true = st.flags.ovf;
      `MDP_C_CARRY: cond_true = st.flags.carry;
      `MDP_C_CNT_ZERO: cond_true = (st.counter_instr_reg == '0);
      `MDP_C_CNT_NIB_ZERO: cond_true = (st.counter_instr_reg[3:0] == 4'h0);
      `MDP_C_INT_PEND: cond_true = st.interrupt_pending_cond;
      `MDP_C_FETCH_SUPP: cond_true = st.fetch_suppressed_flop;
      `MDP_C_SHIFT: cond_true = st.flags.shift_f;
      `MDP_C_Y_SIGN: cond_true = st.flags.y_sign;
      `MDP_C_Y_ZERO: cond_true = st.flags.y_zero;
      `MDP_C_B_SIGN: cond_true = st.flags.b_sign;
      default: cond_true = 1'b0;
    endcase
  end
  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.switch_meta = switch_pins;
    next_st.switch_input_reg = st.switch_meta;
    next_st.int_meta = int_event;
    next_st.int_sync = st.int_meta;
    next_st.interrupt_pending_cond = st.int_sync;
    if (do_store && !zero_fn) begin
      next_st.flags.ovf = alu_ovf;
      next_st.flags.carry = alu_carry;
      next_st.flags.y_sign = y_bus[`MDP_SIGN_BIT];
      next_st.flags.y_zero = (y_bus == '0);
      next_st.flags.b_sign = b_src[`MDP_SIGN_BIT];
      if (shift_en) begin
        next_st.flags.shift_f = shift_out_bit;
      end
    end
    // read tracking for the t register
    case (st.rd_state)
      mdp_pkg::MDP_IDLE: begin
        if (fetch_issue) begin
          next_st.rd_state = mdp_pkg::MDP_FETCH_WAIT;
        end else if (mem_read) begin
          next_st.rd_state = mdp_pkg::MDP_WAIT;
        end
      end
      mdp_pkg::MDP_WAIT: begin
        if (read_done) begin
          next_st.t_reg = read_data;
          next_st.rd_state = mdp_pkg::MDP_IDLE;
        end
      end
      mdp_pkg::MDP_FETCH_WAIT: begin
        if (read_done) begin
          next_st.t_reg = read_data;
          next_st.counter_instr_reg = read_data;
          next_st.rd_state = mdp_pkg::MDP_IDLE;
        end
      end
      default: next_st.rd_state = mdp_pkg::MDP_IDLE;
    endcase
    if (do_store && (condition_field == `MDP_C_CNT_ZERO
        || condition_field == `MDP_C_CNT_NIB_ZERO)) begin
      next_st.counter_instr_reg = st.counter_instr_reg - 16'h0001;
    end
    // store destinations, all at the end of the cycle
    if (do_store) begin
      case (store_dst)
        `MDP_S_COND_ACCUM: begin
          if (st.counter_instr_reg[`MDP_ACC_SEL_BIT]) next_st.acc_b = y_bus;
          else next_st.acc_a = y_bus;
        end
        `MDP_S_COND_INDEX: begin
          if (st.counter_instr_reg[`MDP_IDX_SEL_BIT]) next_st.idx_y = y_bus;
          else next_st.idx_x = y_bus;
        end
        `MDP_S_COUNTER: begin
          next_st.counter_instr_reg = y_bus;
        end
        `MDP_S_INT_STATUS: begin
          next_st.interrupt_status_reg = y_bus;
          next_st.fetch_suppressed_flop = 1'b0;
        end
        `MDP_S_LED: next_st.status_led_latch = y_bus;
        `MDP_S_INDEX: next_st.index_reg = y_bus;
        `MDP_S_SPECIAL_IDX: begin
          if (idx == 4'h0) next_st.map_pointer_reg = y_bus;
        end
        default: ;
      endcase
    end
    // the set beats a clear
    if (do_store && fetch_req && int_req_qual && st.interrupt_pending_cond) begin
      next_st.fetch_suppressed_flop = 1'b1;
    end
  end
  // ----------------------------------------
  // state and register files
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.rd_state <= mdp_pkg::MDP_IDLE;
      st.status_led_latch <= `MDP_RST_LED;
    end else begin
      st <= next_st;
    end
  end
  // file writes, no reset on the arrays
  always_ff @(posedge clk) begin
    if (do_store && store_dst == `MDP_S_GENERAL_IDX) gen_file[idx] <= y_bus;
    if (do_store && store_dst == `MDP_S_PRIV_IDX) priv_file[idx] <= y_bus;
    if (do_store && store_dst == `MDP_S_MAP) begin
      map_file[map_idx] <= y_bus;
    end
  end
endmodule : mdp_datapath
`default_nettype wire
